/* File: inc/scrb_pkg.sv */
// Purpose: shared constants for the synthesizer control register bank
// Assumes: 24-bit serial words, three low bits select the register
// Notes:   field positions are bit indices within the received word
package scrb_pkg;
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned SYNC_STAGES = 3;

  // register select codes
  localparam logic [2:0] ADDR_INT  = 3'h0;
  localparam logic [2:0] ADDR_MOD  = 3'h1;
  localparam logic [2:0] ADDR_FRAC = 3'h2;
  localparam logic [2:0] ADDR_DITH = 3'h3;
  localparam logic [2:0] ADDR_CP   = 3'h4;
  localparam logic [2:0] ADDR_LO   = 3'h5;
  localparam logic [2:0] ADDR_VCO  = 3'h6;
  localparam logic [2:0] ADDR_DIV  = 3'h7;

  // fractional divide register
  localparam int unsigned FRAC_LSB = 3;
  localparam int unsigned FRAC_W   = 11;
  localparam logic [10:0] FRAC_RST = 11'h300;

  // dither control register
  localparam int unsigned DITH_LSB = 3;
  localparam int unsigned DITH_W   = 8;
  localparam logic [7:0]  DITH_MAX = 8'hD9;
  localparam logic [7:0]  DITH_RST = 8'h01;

  // charge pump, offset, reference, monitor register
  localparam int unsigned CP_MULT_LSB = 10;
  localparam int unsigned CP_OFS_LSB  = 12;
  localparam int unsigned CP_OFS_W    = 5;
  localparam int unsigned CP_SIGN_BIT = 17;
  localparam int unsigned CP_BIAS_RESISTOR_BIT = 18;
  localparam int unsigned CP_REF_LSB  = 19;
  localparam int unsigned CP_MON_LSB  = 21;
  localparam logic [1:0]  REF_X2      = 2'h0;
  localparam logic [1:0]  REF_X1      = 2'h1;
  localparam logic [1:0]  REF_HALF    = 2'h2;
  localparam logic [1:0]  REF_QUARTER = 2'h3;
  localparam logic [2:0]  MON_LOCK    = 3'h0;
  localparam logic [2:0]  MON_LOW     = 3'h1;
  localparam logic [2:0]  MON_HIGH    = 3'h2;
  localparam logic [2:0]  MON_CAL     = 3'h3;

  // lo path and demodulator register
  localparam int unsigned LO_DIR_BIT = 3;
  localparam int unsigned LO_DRV_BIT = 4;
  localparam int unsigned LO_LP_BIT  = 5;

  // vco control and enables register
  localparam int unsigned VCO_BAND_LSB = 3;
  localparam int unsigned VCO_BAND_W   = 6;
  localparam int unsigned VCO_BSRC_BIT = 9;
  localparam int unsigned VCO_AMP_LSB  = 10;
  localparam int unsigned VCO_AMP_W    = 5;
  localparam int unsigned VCO_CP_BIT   = 16;
  localparam int unsigned VCO_EN_BIT   = 17;
  localparam int unsigned VCO_LDO_BIT  = 18;
  localparam logic [4:0]  VCO_AMP_RST  = 5'h18;

  // lo divider register
  localparam int unsigned DIV_OUT_LSB  = 4;
  localparam int unsigned DIV_MAIN_LSB = 6;
  localparam logic [3:0]  DIV_MAIN_X4  = 4'h0;
  localparam logic [1:0]  DIV_OUT_X4   = 2'h1;
  localparam logic [1:0]  DIV_OUT_X6   = 2'h2;
  localparam logic [1:0]  DIV_OUT_X8   = 2'h3;
endpackage : scrb_pkg

/* File: rtl/scrb_sync3.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to i_clk
// Notes:   output moves only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module scrb_sync3 (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // async level in, clean level out
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign o_level = level_ff;
endmodule : scrb_sync3
`default_nettype wire

/* File: rtl/scrb_shift_in.sv */
// Purpose: serial word shifter on the link clock
// Assumes: data sampled on rising link clock while latch enable is low
// Notes:   the last 24 bits shifted in form the word, msb first
`timescale 1ns/100ps
`default_nettype none
module scrb_shift_in
  import scrb_pkg::*;
(
  // link clock and reset
  input  wire logic              i_link_clk,
  input  wire logic              i_reset_n,
  // serial pins
  input  wire logic              i_serial_data,
  input  wire logic              i_latch_enable,
  // assembled word
  output logic [WORD_W-1:0]      o_word
);
  logic [WORD_W-1:0] word_ff;

  // shifting stops while the latch is high so the word is stable for capture
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_ff <= '0;
    end else if (!i_latch_enable) begin
      word_ff <= {word_ff[WORD_W-2:0], i_serial_data};
    end
  end

  assign o_word = word_ff;
endmodule : scrb_shift_in
`default_nettype wire

/* File: rtl/scrb_ctrl_bank.sv */
// Purpose: serially written control register bank of the synthesizer
// Assumes: link clock still while latch enable is high
// Notes:   the latched word crosses on the synchronised latch edge
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - select 010 loads 11-bit fraction from bits 13 down to 3.
// - select 011 loads dither restart, accepting values 0 to 217.
// - select 100 loads pump, offset, reference and monitor settings.
// - bit 18 picks internal or external pump bias resistor.
// - pump current multiplier is one plus bits 11 and 10.
// - bits 16 to 12 set phase offset magnitude field.
// - bit 17 sets phase offset direction.
// - reference scaled by two, one, half or quarter.
// - monitor pin shows selected signal, lock detect after reset.
// - register five bit 5 selects reduced mixer current.
// - register five sets lo pin direction and lo driver enable.
// - select 110 loads vco control and enables.
// - band source picks calibration result or serial band value.
// - vco amplitude 0 to 31, 24 after reset.
// - separate enables for vco, regulator and pump, pump on by default.
// - register seven bits 9 to 6 set main divider, 0000 is four.
// - bits 5 and 4 set output divider: 8, 6 or 4.
// - any write to register zero, one or two starts calibration.
module scrb_ctrl_bank
  import scrb_pkg::*;
(
  // core clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  // serial link
  input  wire logic                       i_link_clk,
  input  wire logic                       i_serial_data,
  input  wire logic                       i_latch_enable,
  // internal status in
  input  wire logic                       i_lock_detect,
  input  wire logic [scrb_pkg::VCO_BAND_W-1:0] i_band_calibration,
  // synthesizer controls
  output logic                            o_cal_start,
  output logic [scrb_pkg::FRAC_W-1:0]     o_fraction,
  output logic [scrb_pkg::DITH_W-1:0]     o_dither_restart,
  output logic                            o_bias_resistor_ext,
  output logic                            o_phase_offset_negative,
  output logic [scrb_pkg::CP_OFS_W-1:0]   o_phase_offset_field,
  output logic [2:0]                      o_pump_current_multiplier,
  output logic [1:0]                      o_ref_scale,
  output logic                            o_monitor_output_pin,
  // lo path
  output logic                            o_low_power_select,
  output logic                            o_lo_pin_input,
  output logic                            o_lo_drive_enable,
  output logic [3:0]                      o_lo_main_div,
  output logic [3:0]                      o_lo_main_ratio,
  output logic [1:0]                      o_lo_out_div,
  output logic [3:0]                      o_lo_out_ratio,
  // vco
  output logic                            o_band_source_select,
  output logic [scrb_pkg::VCO_BAND_W-1:0] o_vco_band,
  output logic [scrb_pkg::VCO_AMP_W-1:0]  o_vco_amplitude,
  output logic                            o_vco_enable,
  output logic                            o_vco_regulator_enable,
  output logic                            o_charge_pump_enable
);
  import scrb_pkg::*;

  logic [WORD_W-1:0]     link_word;
  logic                  latch_level;
  logic                  latch_low;
  logic                  lock_level;
  logic                  latch_prev_ff;
  logic [WORD_W-1:0]     word_ff;
  logic                  wr_stb_ff;
  logic [ADDR_W-1:0]     wr_addr;
  logic                  cal_start_ff;
  logic [FRAC_W-1:0]     fraction_ff;
  logic [DITH_W-1:0]     dither_ff;
  logic                  bias_resistor_ext_ff;
  logic                  ofs_neg_ff;
  logic [CP_OFS_W-1:0]   ofs_field_ff;
  logic [2:0]            mult_ff;
  logic [1:0]            ref_scale_ff;
  logic [2:0]            mon_sel_ff;
  logic                  monitor_ff;
  logic                  low_power_ff;
  logic                  lo_input_ff;
  logic                  lo_drive_ff;
  logic [3:0]            main_div_ff;
  logic [3:0]            main_ratio_ff;
  logic [1:0]            out_div_ff;
  logic [3:0]            out_ratio_ff;
  logic                  band_src_ff;
  logic [VCO_BAND_W-1:0] band_serial_ff;
  logic [VCO_BAND_W-1:0] vco_band_ff;
  logic [VCO_AMP_W-1:0]  amp_ff;
  logic                  vco_en_ff;
  logic                  ldo_en_ff;
  logic                  cp_en_ff;
  logic [DITH_W-1:0]     nxt_dither;
  logic [3:0]            nxt_out_ratio;

  scrb_shift_in u_shift (
    .i_link_clk     (i_link_clk),
    .i_reset_n      (i_reset_n),
    .i_serial_data  (i_serial_data),
    .i_latch_enable (i_latch_enable),
    .o_word         (link_word)
  );

  scrb_sync3 u_latch_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (!i_latch_enable),
    .o_level   (latch_low)
  );

  // inverse is synchronised so the reset value matches the idle-high pin: no false write
  assign latch_level = !latch_low;

  scrb_sync3 u_lock_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_lock_detect),
    .o_level   (lock_level)
  );

  // the link word is frozen while the latch is high, so sampling it
  // after the synchronised rising edge is a safe multi-bit crossing
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_prev_ff <= 1'b1;
      wr_stb_ff     <= 1'b0;
      word_ff       <= '0;
    end else begin
      latch_prev_ff <= latch_level;
      wr_stb_ff     <= latch_level && !latch_prev_ff;
      if (latch_level && !latch_prev_ff) begin
        word_ff <= link_word;
      end
    end
  end

  assign wr_addr    = word_ff[ADDR_W-1:0];
  assign nxt_dither = word_ff[DITH_LSB +: DITH_W];

  // writes to the integer, modulus or fraction register restart band cal
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cal_start_ff <= 1'b0;
    end else begin
      cal_start_ff <= wr_stb_ff && (wr_addr <= ADDR_FRAC);
    end
  end

  // only the field bits are stored, everything else in the word is dropped
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fraction_ff <= FRAC_RST;
      dither_ff   <= DITH_RST;
    end else if (wr_stb_ff) begin
      if (wr_addr == ADDR_FRAC) begin
        fraction_ff <= word_ff[FRAC_LSB +: FRAC_W];
      end
      // out-of-range restart values are refused, the old value stays
      if (wr_addr == ADDR_DITH && nxt_dither <= DITH_MAX) begin
        dither_ff <= nxt_dither;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bias_resistor_ext_ff  <= 1'b0;
      ofs_neg_ff   <= 1'b0;
      ofs_field_ff <= '0;
      mult_ff      <= 3'h1;
      ref_scale_ff <= REF_X1;
      mon_sel_ff   <= MON_LOCK;
    end else if (wr_stb_ff && wr_addr == ADDR_CP) begin
      bias_resistor_ext_ff  <= word_ff[CP_BIAS_RESISTOR_BIT];
      ofs_neg_ff   <= word_ff[CP_SIGN_BIT];
      ofs_field_ff <= word_ff[CP_OFS_LSB +: CP_OFS_W];
      mult_ff      <= {1'b0, word_ff[CP_MULT_LSB +: 2]} + 3'h1;
      ref_scale_ff <= word_ff[CP_REF_LSB +: 2];
      mon_sel_ff   <= word_ff[CP_MON_LSB +: 3];
    end
  end

  // monitor pin follows the chosen internal signal
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      monitor_ff <= 1'b0;
    end else begin
      unique case (mon_sel_ff)
        MON_LOCK: monitor_ff <= lock_level;
        MON_HIGH: monitor_ff <= 1'b1;
        MON_CAL:  monitor_ff <= cal_start_ff;
        default:  monitor_ff <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_power_ff <= 1'b0;
      lo_input_ff  <= 1'b0;
      lo_drive_ff  <= 1'b0;
    end else if (wr_stb_ff && wr_addr == ADDR_LO) begin
      low_power_ff <= word_ff[LO_LP_BIT];
      lo_input_ff  <= word_ff[LO_DIR_BIT];
      lo_drive_ff  <= word_ff[LO_DRV_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      band_src_ff    <= 1'b0;
      band_serial_ff <= '0;
      amp_ff         <= VCO_AMP_RST;
      vco_en_ff      <= 1'b1;
      ldo_en_ff      <= 1'b1;
      cp_en_ff       <= 1'b1;
    end else if (wr_stb_ff && wr_addr == ADDR_VCO) begin
      band_src_ff    <= word_ff[VCO_BSRC_BIT];
      band_serial_ff <= word_ff[VCO_BAND_LSB +: VCO_BAND_W];
      amp_ff         <= word_ff[VCO_AMP_LSB +: VCO_AMP_W];
      vco_en_ff      <= word_ff[VCO_EN_BIT];
      ldo_en_ff      <= word_ff[VCO_LDO_BIT];
      cp_en_ff       <= word_ff[VCO_CP_BIT];
    end
  end

  // band follows calibration live unless the serial value is selected
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vco_band_ff <= '0;
    end else begin
      vco_band_ff <= band_src_ff ? band_serial_ff : i_band_calibration;
    end
  end

  always_comb begin
    unique case (word_ff[DIV_OUT_LSB +: 2])
      DIV_OUT_X8: nxt_out_ratio = 4'h8;
      DIV_OUT_X6: nxt_out_ratio = 4'h6;
      DIV_OUT_X4: nxt_out_ratio = 4'h4;
      default:    nxt_out_ratio = 4'h0;
    endcase
  end

  // unlisted divider codes report ratio zero rather than a guess
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      main_div_ff   <= DIV_MAIN_X4;
      main_ratio_ff <= 4'h4;
      out_div_ff    <= DIV_OUT_X4;
      out_ratio_ff  <= 4'h4;
    end else if (wr_stb_ff && wr_addr == ADDR_DIV) begin
      main_div_ff   <= word_ff[DIV_MAIN_LSB +: 4];
      main_ratio_ff <= (word_ff[DIV_MAIN_LSB +: 4] == DIV_MAIN_X4) ? 4'h4 : 4'h0;
      out_div_ff    <= word_ff[DIV_OUT_LSB +: 2];
      out_ratio_ff  <= nxt_out_ratio;
    end
  end

  assign o_cal_start               = cal_start_ff;
  assign o_fraction                = fraction_ff;
  assign o_dither_restart          = dither_ff;
  assign o_bias_resistor_ext       = bias_resistor_ext_ff;
  assign o_phase_offset_negative   = ofs_neg_ff;
  assign o_phase_offset_field      = ofs_field_ff;
  assign o_pump_current_multiplier = mult_ff;
  assign o_ref_scale               = ref_scale_ff;
  assign o_monitor_output_pin      = monitor_ff;
  assign o_low_power_select        = low_power_ff;
  assign o_lo_pin_input            = lo_input_ff;
  assign o_lo_drive_enable         = lo_drive_ff;
  assign o_lo_main_div             = main_div_ff;
  assign o_lo_main_ratio           = main_ratio_ff;
  assign o_lo_out_div              = out_div_ff;
  assign o_lo_out_ratio            = out_ratio_ff;
  assign o_band_source_select      = band_src_ff;
  assign o_vco_band                = vco_band_ff;
  assign o_vco_amplitude           = amp_ff;
  assign o_vco_enable              = vco_en_ff;
  assign o_vco_regulator_enable    = ldo_en_ff;
  assign o_charge_pump_enable      = cp_en_ff;

  property p_frac_load;
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_stb_ff && wr_addr == ADDR_FRAC |=> o_fraction == $past(word_ff[13:3]);
  endproperty
  a_frac_load: assert property (p_frac_load)
    else $error("fraction not loaded from written word");

  property p_dith_range;
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_stb_ff && wr_addr == ADDR_DITH |=>
      o_dither_restart == (($past(nxt_dither) <= 8'hD9) ?
                           $past(nxt_dither) : $past(o_dither_restart));
  endproperty
  a_dith_range: assert property (p_dith_range)
    else $error("dither restart load or refusal wrong");

  property p_cp_fields;
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_stb_ff && wr_addr == ADDR_CP |=>
      o_pump_current_multiplier == {1'b0, $past(word_ff[11:10])} + 3'h1 &&
      o_phase_offset_field == $past(word_ff[16:12]) &&
      o_phase_offset_negative == $past(word_ff[17]) &&
      o_bias_resistor_ext == $past(word_ff[18]);
  endproperty
  a_cp_fields: assert property (p_cp_fields)
    else $error("charge pump fields do not match written word");

  property p_cal_start;
    @(posedge i_clk) disable iff (!i_reset_n)
    o_cal_start == $past(wr_stb_ff && word_ff[2:0] <= 3'h2);
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration start does not match frequency write");

  property p_low_power;
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_stb_ff && wr_addr == ADDR_LO |=>
      o_low_power_select == $past(word_ff[5]) && o_lo_pin_input == $past(word_ff[3]);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("lo path register not loaded");

  property p_vco_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
    !(wr_stb_ff && wr_addr == ADDR_VCO) |=>
      $stable(o_vco_amplitude) && $stable(o_charge_pump_enable) && $stable(o_vco_enable);
  endproperty
  a_vco_hold: assert property (p_vco_hold)
    else $error("vco settings changed without a write");

  property p_band_source;
    @(posedge i_clk) disable iff (!i_reset_n)
    ##1 o_vco_band == ($past(o_band_source_select) ?
                       $past(band_serial_ff) : $past(i_band_calibration));
  endproperty
  a_band_source: assert property (p_band_source)
    else $error("vco band taken from the wrong source");

  property p_out_ratio;
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_stb_ff && wr_addr == ADDR_DIV && word_ff[5:4] == 2'h3 |=> o_lo_out_ratio == 4'h8;
  endproperty
  a_out_ratio: assert property (p_out_ratio)
    else $error("output divider code 11 not decoded as eight");

  property p_monitor_lock;
    @(posedge i_clk) disable iff (!i_reset_n)
    mon_sel_ff == MON_LOCK |=> o_monitor_output_pin == $past(lock_level);
  endproperty
  a_monitor_lock: assert property (p_monitor_lock)
    else $error("monitor pin not following lock detect");

  property p_write_latency;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(latch_level) |=> wr_stb_ff ##1 !wr_stb_ff;
  endproperty
  a_write_latency: assert property (p_write_latency)
    else $error("latch edge did not give a single write strobe");
endmodule : scrb_ctrl_bank
`default_nettype wire

/* File: testbench/scrb_host_model.sv */
// Purpose: serial host that writes 24-bit words into the register bank
// Assumes: link clock idles low between frames, latch idles high
// Notes:   data shows the inverse of its last bit once a frame is over
`timescale 1ns/100ps
`default_nettype none
module scrb_host_model (
  // serial pins
  output var logic o_link_clk,
  output var logic o_serial_data,
  output var logic o_latch_enable
);
  initial begin
    o_link_clk     = 1'b0;
    o_serial_data  = 1'b0;
    o_latch_enable = 1'b1;
  end

  // data moves on the falling link edge so it is settled at the rising one
  task automatic send(input logic [23:0] word);
    #3.3;
    o_latch_enable = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_serial_data = word[i];
      #16 o_link_clk = 1'b1;
      #16 o_link_clk = 1'b0;
    end
    // the released line must not keep showing a valid bit
    o_serial_data = ~word[0];
    #16 o_latch_enable = 1'b1;
    // latch stays high well past the core's sync delay
    #200;
  endtask : send
endmodule : scrb_host_model
`default_nettype wire

/* File: testbench/scrb_ctrl_bank_tb_top.sv */
// Purpose: self-checking bench for the control register bank
// Assumes: host model frames words; core and link clocks unrelated
// Notes:   expectations come from a shadow copy of each written word
`timescale 1ns/100ps
`default_nettype none
module scrb_ctrl_bank_tb_top;
  import scrb_pkg::*;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_lock_detect = 1'b0;
  logic [5:0]  i_band_calibration = 6'h00;
  wire logic   link_clk, ser_data, latch_en, cal_start;
  wire logic [63:0] act;
  logic [23:0] w [8];
  logic [63:0] q [$];
  logic [3:0]  cq [$];
  int          err_total = 0;
  int          total_checks = 0;

  always #5 i_clk = ~i_clk;

  scrb_host_model scrb_host_model_i (.o_link_clk(link_clk), .o_serial_data(ser_data),
    .o_latch_enable(latch_en));

  scrb_ctrl_bank scrb_ctrl_bank_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_link_clk(link_clk), .i_serial_data(ser_data), .i_latch_enable(latch_en),
    .i_lock_detect(i_lock_detect), .i_band_calibration(i_band_calibration),
    .o_cal_start(cal_start), .o_fraction(act[63:53]), .o_dither_restart(act[52:45]),
    .o_bias_resistor_ext(act[44]), .o_phase_offset_negative(act[43]),
    .o_phase_offset_field(act[42:38]), .o_pump_current_multiplier(act[37:35]),
    .o_ref_scale(act[34:33]), .o_low_power_select(act[32]), .o_lo_pin_input(act[31]),
    .o_lo_drive_enable(act[30]), .o_lo_main_div(act[29:26]), .o_lo_main_ratio(act[25:22]),
    .o_lo_out_div(act[21:20]), .o_lo_out_ratio(act[19:16]),
    .o_band_source_select(act[15]), .o_vco_band(act[14:9]), .o_vco_amplitude(act[8:4]),
    .o_vco_enable(act[3]), .o_vco_regulator_enable(act[2]),
    .o_charge_pump_enable(act[1]), .o_monitor_output_pin(act[0]));

  function automatic logic [63:0] expect_of();
    logic [1:0] o;
    o = w[7][5:4];
    return {w[2][13:3], w[3][10:3], w[4][18], w[4][17], w[4][16:12],
      3'h1 + {1'b0, w[4][11:10]}, w[4][20:19], w[5][5], w[5][3], w[5][4],
      w[7][9:6], (w[7][9:6] == 4'h0) ? 4'h4 : 4'h0,
      o, (o == 2'h3) ? 4'h8 : (o == 2'h2) ? 4'h6 : (o == 2'h1) ? 4'h4 : 4'h0,
      w[6][9], w[6][9] ? w[6][8:3] : i_band_calibration, w[6][14:10],
      w[6][17], w[6][18], w[6][16],
      (w[4][23:21] == 3'h2) | ((w[4][23:21] == 3'h0) & i_lock_detect)};
  endfunction : expect_of

  task automatic wr(input logic [23:0] d);
    // out-of-range dither restart leaves the shadow untouched
    if (!(d[2:0] == 3'h3 && d[10:3] > 8'hD9)) w[d[2:0]] = d;
    q.push_back(expect_of());
    cq.push_back((d[2:0] <= 3'h2) ? 4'h1 : 4'h0);
    scrb_host_model_i.send(d);
  endtask : wr

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // each latch edge ends one write: count calibration start pulses, then compare the settled fields
  initial begin : watch
    logic [63:0] e;
    logic [3:0]  n;
    logic [3:0]  c;
    #1;
    forever begin
      @(posedge latch_en);
      n = 4'h0;
      // sampled away from the edge that launches the pulse
      repeat (10) @(negedge i_clk) n = n + {3'h0, cal_start};
      @(negedge i_clk);
      e = q.pop_front();
      c = cq.pop_front();
      `CHK(n, c)
      `CHK(act[63:33], e[63:33])
      `CHK(act[32:0], e[32:0])
    end
  end

  initial begin : timeout
    #200us;
    err_total++;
    print_verdict();
  end

  initial begin : main
    int seed;
    logic [23:0] d;
    seed = 32'hC82600C9;
    w = '{24'h0, 24'h3001, 24'h1802, 24'hB, 24'h80004, 24'h5, 24'h76006, 24'h17};
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (6) @(negedge i_clk);
    `CHK(act, expect_of())
    // bring-up from seven down to zero, dither restart one
    for (int r = 7; r >= 0; r--) wr(w[r]);
    for (int o = 1; o <= 3; o++) wr({14'h0, 4'h0, o[1:0], 4'h7});
    for (int m = 0; m <= 3; m++) begin
      @(negedge i_clk);
      i_lock_detect = ~m[0];
      wr({m[2:0], m[1:0], 16'h0, 3'h4});
    end
    wr(24'h6CB);
    wr(24'h6D3);
    wr(24'h123450);
    wr(24'h123450);
    wr(24'h003001);
    for (int k = 0; k < 40; k++) begin
      @(negedge i_clk);
      i_lock_detect = 1'($random(seed));
      i_band_calibration = 6'($random(seed));
      d = 24'($random(seed));
      // modulus held at 1536 so every random fraction stays below it
      if (d[2:0] == 3'h1) d[13:3] = 11'h600;
      if (d[2:0] == 3'h2) d[13:3] = d[13:3] % 11'd1536;
      if (d[2:0] == 3'h7) begin
        d[9:6] = 4'h0;
        if (d[5:4] == 2'h0) d[5:4] = 2'h1;
      end
      wr(d);
    end
    for (int k = 0; k < 100 && q.size() != 0; k++) @(negedge i_clk);
    if (q.size() != 0) err_total++;
    print_verdict();
  end
endmodule : scrb_ctrl_bank_tb_top
`default_nettype wire
